/* File: rtl/vee_consts.svh */
`ifndef VEE_CONSTS_SVH
`define VEE_CONSTS_SVH

// egress subclass geometry
`define VEE_FILL_W 6
`define VEE_NSUB 10
`define VEE_LANES 8
`define VEE_SUM_W 9
`define VEE_MAIN_N 7
`define VEE_ACK2_BASE 7
`define VEE_ACK2_N 2
`define VEE_STARVE_N 3

// counter and starvation figures
`define VEE_CNT_W 48
`define VEE_STARVE_LIMIT 256
`define VEE_STOP_W 6

// register byte offsets
`define VEE_ADDR_W 12
`define VEE_OFF_CTRL 12'h000
`define VEE_OFF_CNT_LO 12'h004
`define VEE_OFF_CNT_HI 12'h008
`define VEE_OFF_STATUS 12'h00C

// control register fields
`define VEE_CTRL_EV_LSB 0
`define VEE_CTRL_MASK_LSB 8
`define VEE_CTRL_EN_BIT 16
`define VEE_CTRL_CLR_BIT 17
`define VEE_CTRL_RST 18'h00000

// status register fields
`define VEE_STAT_LEFT_BIT 0
`define VEE_STAT_STARVE_LSB 1
`define VEE_STAT_BADEV_BIT 11

// event codes
`define VEE_EV_FILL0 8'h90
`define VEE_EV_FILL1 8'h91
`define VEE_EV_ALLOC0 8'h92
`define VEE_EV_ALLOC1 8'h93
`define VEE_EV_NE0 8'h96
`define VEE_EV_NE1 8'h97
`define VEE_EV_REFUSE0 8'h98
`define VEE_EV_REFUSE1 8'h99
`define VEE_EV_STARVE0 8'h9A
`define VEE_EV_STARVE1 8'h9B
`define VEE_EV_RING_USE 8'hB0

`endif

/* File: rtl/vee_pkg.sv */
package vee_pkg;
`include "vee_consts.svh"

    // one egress subclass as seen by the monitor
    typedef struct packed {
        logic [`VEE_FILL_W-1:0] fill;
        logic alloc;
        logic refused;
        logic sent;
    } vee_egress_s;

    // slot order: 0 cw even, 1 cw odd, 2 ccw even, 3 ccw odd
    typedef struct packed {
        logic [3:0] occupied;
        logic [3:0] own_inject;
    } vee_ring_s;

    typedef struct packed {
        logic [31:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } vee_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } vee_apb_rsp_s;

    typedef enum logic [7:0] {
        VEE_FILL0 = `VEE_EV_FILL0,
        VEE_FILL1 = `VEE_EV_FILL1,
        VEE_ALLOC0 = `VEE_EV_ALLOC0,
        VEE_ALLOC1 = `VEE_EV_ALLOC1,
        VEE_NE0 = `VEE_EV_NE0,
        VEE_NE1 = `VEE_EV_NE1,
        VEE_REFUSE0 = `VEE_EV_REFUSE0,
        VEE_REFUSE1 = `VEE_EV_REFUSE1,
        VEE_STARVE0 = `VEE_EV_STARVE0,
        VEE_STARVE1 = `VEE_EV_STARVE1,
        VEE_RING_USE = `VEE_EV_RING_USE
    } vee_event_e;

endpackage : vee_pkg

/* File: rtl/vee_lane_sum.sv */
`timescale 1ns/10ps
`include "vee_consts.svh"

module vee_lane_sum #(
    parameter int LANES = `VEE_LANES,
    parameter int LW = `VEE_FILL_W,
    parameter int SW = `VEE_SUM_W
) (
    // lanes and their enables
    input wire logic [LANES-1:0] mask_i,
    input wire logic [LANES*LW-1:0] lanes_i,
    // combined contribution
    output logic [SW-1:0] sum_o
);

    logic [SW-1:0] partial [LANES+1];

    assign partial[0] = '0;

    genvar k;
    generate
        for (k = 0; k < LANES; k++) begin : g_lane
            logic [SW-1:0] masked;
            // a clear mask bit drops the lane entirely
            assign masked = mask_i[k] ?
                {{(SW-LW){1'b0}}, lanes_i[k*LW +: LW]} : '0;
            assign partial[k+1] = partial[k] + masked;
        end
    endgenerate

    assign sum_o = partial[LANES];

endmodule : vee_lane_sum

/* File: rtl/vee_counter.sv */
`timescale 1ns/10ps
`include "vee_consts.svh"

module vee_counter #(
    parameter int CNT_W = `VEE_CNT_W,
    parameter int STOP_W = `VEE_STOP_W,
    parameter int STARVE_LIMIT = `VEE_STARVE_LIMIT
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // register bus
    input wire vee_pkg::vee_apb_req_s apb_i,
    output vee_pkg::vee_apb_rsp_s apb_o,
    // mesh stop observation
    input wire vee_pkg::vee_egress_s [`VEE_NSUB-1:0] egress_i,
    input wire vee_pkg::vee_ring_s ring_i,
    // stop placement
    input wire logic [STOP_W-1:0] stop_id_i,
    input wire logic [STOP_W:0] stop_count_i
);
    import vee_pkg::*;

    localparam int NSUB = `VEE_NSUB;
    localparam int LANES = `VEE_LANES;
    localparam int FW = `VEE_FILL_W;
    localparam int SW = `VEE_SUM_W;
    localparam int WAIT_W = $clog2(STARVE_LIMIT + 1);
    localparam logic [WAIT_W-1:0] WAIT_MAX = WAIT_W'(STARVE_LIMIT);

    // ---------------- bus decode ----------------
    logic setup;
    logic access;
    logic [`VEE_ADDR_W-1:0] word_addr;
    logic upper_zero;
    logic hit_ctrl;
    logic hit_lo;
    logic hit_hi;
    logic hit_stat;
    logic mapped;
    logic wr_en;

    assign setup = apb_i.psel & ~apb_i.penable;
    // the bus waits while the block is frozen, so no write is lost
    assign access = apb_i.psel & apb_i.penable & ce_i;
    assign word_addr = apb_i.paddr[`VEE_ADDR_W-1:0];
    assign upper_zero = ~|apb_i.paddr[31:`VEE_ADDR_W];
    assign hit_ctrl = upper_zero & (word_addr == `VEE_OFF_CTRL);
    assign hit_lo = upper_zero & (word_addr == `VEE_OFF_CNT_LO);
    assign hit_hi = upper_zero & (word_addr == `VEE_OFF_CNT_HI);
    assign hit_stat = upper_zero & (word_addr == `VEE_OFF_STATUS);
    assign mapped = hit_ctrl | hit_lo | hit_hi | hit_stat;
    assign wr_en = access & apb_i.pwrite & mapped;

    // ---------------- control register ----------------
    logic [7:0] ev_code;
    logic [LANES-1:0] umask;
    logic count_en;
    logic [17:0] ctrl_word;
    logic [17:0] next_ctrl;
    logic clr_req;

    assign ctrl_word = {1'b0, count_en, umask, ev_code};

    always_comb begin
        next_ctrl = ctrl_word;
        if (wr_en & hit_ctrl) begin
            if (apb_i.pstrb[0]) begin
                next_ctrl[7:0] = apb_i.pwdata[7:0];
            end
            if (apb_i.pstrb[1]) begin
                next_ctrl[15:8] = apb_i.pwdata[15:8];
            end
            if (apb_i.pstrb[2]) begin
                next_ctrl[16] = apb_i.pwdata[`VEE_CTRL_EN_BIT];
            end
        end
    end

    // clear is a write-one strobe, it never reads back
    assign clr_req = wr_en & hit_ctrl & apb_i.pstrb[2] &
        apb_i.pwdata[`VEE_CTRL_CLR_BIT];

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            {count_en, umask, ev_code} <= 17'(`VEE_CTRL_RST);
        end else if (ce_i) begin
            {count_en, umask, ev_code} <= next_ctrl[16:0];
        end
    end

    // ---------------- per-subclass state ----------------
    logic [NSUB-1:0] nonempty;
    logic [NSUB-1:0] starved;

    genvar s;
    generate
        for (s = 0; s < NSUB; s++) begin : g_sub
            logic [WAIT_W-1:0] wait_cnt;
            logic [WAIT_W-1:0] next_wait;
            assign nonempty[s] = |egress_i[s].fill;
            // a send or an empty queue ends the wait; it saturates
            assign next_wait = (~nonempty[s] | egress_i[s].sent) ? '0 :
                (wait_cnt == WAIT_MAX) ? wait_cnt : wait_cnt + 1'b1;
            assign starved[s] = (wait_cnt == WAIT_MAX);
            always_ff @(posedge clk_i) begin
                if (sys_rst_i) begin
                    wait_cnt <= '0;
                end else if (ce_i) begin
                    wait_cnt <= next_wait;
                end
            end
        end
    endgenerate

    // ---------------- vertical request ring ----------------
    logic left_side;
    logic [3:0] slot_use;
    logic [1:0] up_use;
    logic [1:0] dn_use;
    logic [3:0] ring_lanes;

    // stop_id below half of the stop count sits on the left side
    assign left_side = ({1'b0, stop_id_i} << 1) < {1'b0, stop_count_i};
    // passing and sunk packets count, own injections do not
    assign slot_use = ring_i.occupied & ~ring_i.own_inject;
    assign up_use = left_side ? slot_use[1:0] : slot_use[3:2];
    assign dn_use = left_side ? slot_use[3:2] : slot_use[1:0];
    assign ring_lanes = {dn_use, up_use};

    // ---------------- lane selection ----------------
    logic [LANES*FW-1:0] lane_flat;
    logic known_ev;

    assign known_ev = (ev_code == VEE_FILL0) || (ev_code == VEE_FILL1) ||
        (ev_code == VEE_ALLOC0) || (ev_code == VEE_ALLOC1) ||
        (ev_code == VEE_NE0) || (ev_code == VEE_NE1) ||
        (ev_code == VEE_REFUSE0) || (ev_code == VEE_REFUSE1) ||
        (ev_code == VEE_STARVE0) || (ev_code == VEE_STARVE1) ||
        (ev_code == VEE_RING_USE);

    genvar k;
    generate
        for (k = 0; k < LANES; k++) begin : g_sel
            // index clamps keep unused lanes off nonexistent subclasses
            localparam int MI = (k < `VEE_MAIN_N) ? k : 0;
            localparam int AI = (k < `VEE_STARVE_N) ?
                `VEE_ACK2_BASE + k : `VEE_ACK2_BASE;
            localparam bit IN_MAIN = (k < `VEE_MAIN_N);
            localparam bit IN_ACK2 = (k < `VEE_ACK2_N);
            localparam bit IN_STRV = (k < `VEE_STARVE_N);
            localparam bit IN_RING = (k < 4);
            localparam int RI = IN_RING ? k : 0;
            logic [FW-1:0] lane;

            always_comb begin
                lane = '0;
                case (ev_code)
                    VEE_FILL0: begin
                        if (IN_MAIN) lane = egress_i[MI].fill;
                    end
                    VEE_FILL1: begin
                        if (IN_ACK2) lane = egress_i[AI].fill;
                    end
                    VEE_ALLOC0: begin
                        if (IN_MAIN) lane[0] = egress_i[MI].alloc;
                    end
                    VEE_ALLOC1: begin
                        if (IN_ACK2) lane[0] = egress_i[AI].alloc;
                    end
                    VEE_NE0: begin
                        if (IN_MAIN) lane[0] = nonempty[MI];
                    end
                    VEE_NE1: begin
                        if (IN_ACK2) lane[0] = nonempty[AI];
                    end
                    VEE_REFUSE0: begin
                        if (IN_MAIN) lane[0] = egress_i[MI].refused;
                    end
                    VEE_REFUSE1: begin
                        if (IN_ACK2) lane[0] = egress_i[AI].refused;
                    end
                    VEE_STARVE0: begin
                        if (IN_MAIN) lane[0] = starved[MI];
                    end
                    VEE_STARVE1: begin
                        if (IN_STRV) lane[0] = starved[AI];
                    end
                    VEE_RING_USE: begin
                        if (IN_RING) lane[0] = ring_lanes[RI];
                    end
                    default: begin
                        lane = '0;
                    end
                endcase
            end

            assign lane_flat[k*FW +: FW] = lane;
        end
    endgenerate

    // ---------------- accumulate ----------------
    logic [SW-1:0] inc;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;

    vee_lane_sum #(
        .LANES(LANES),
        .LW(FW),
        .SW(SW)
    ) u_sum (
        .mask_i(umask),
        .lanes_i(lane_flat),
        .sum_o(inc)
    );

    // clear wins over a same-cycle increment so software sees zero
    assign next_count = clr_req ? '0 :
        count_en ? count + {{(CNT_W-SW){1'b0}}, inc} : count;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            count <= '0;
        end else if (ce_i) begin
            count <= next_count;
        end
    end

    // ---------------- read path ----------------
    logic [31:0] count_lo;
    logic [31:0] count_hi;
    logic [31:0] hi_shadow;
    logic [31:0] status_word;
    logic [31:0] rd_mux;
    logic [31:0] rdata;
    logic lo_read;

    assign count_lo = count[31:0];
    assign count_hi = 32'(count[CNT_W-1:32]);
    assign status_word = {20'h00000, ~known_ev, starved, left_side};
    // the high word is frozen at the same setup edge that latches the low
    // word, so a pair read never straddles a carry
    assign lo_read = setup & ~apb_i.pwrite & hit_lo;

    assign rd_mux = hit_ctrl ? {14'h0000, ctrl_word} :
        hit_lo ? count_lo :
        hit_hi ? hi_shadow :
        hit_stat ? status_word : 32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            hi_shadow <= 32'h0000_0000;
            rdata <= 32'h0000_0000;
        end else if (ce_i) begin
            if (lo_read) begin
                hi_shadow <= count_hi;
            end
            if (setup & ~apb_i.pwrite) begin
                rdata <= rd_mux;
            end
        end
    end

    assign apb_o.prdata = rdata;
    assign apb_o.pready = access;
    assign apb_o.pslverr = access & ~mapped;

endmodule : vee_counter

/* File: dv/vee_counter_monitor.sv */
`timescale 1ns/10ps
`include "vee_consts.svh"
module vee_counter_monitor #(
    parameter int CNT_W = `VEE_CNT_W,
    parameter int STOP_W = `VEE_STOP_W,
    parameter int STARVE_LIMIT = `VEE_STARVE_LIMIT
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // register bus
    input wire vee_pkg::vee_apb_req_s apb_i,
    input wire vee_pkg::vee_apb_rsp_s apb_o,
    // observation and placement
    input wire vee_pkg::vee_egress_s [`VEE_NSUB-1:0] egress_i,
    input wire vee_pkg::vee_ring_s ring_i,
    input wire logic [STOP_W-1:0] stop_id_i,
    input wire logic [STOP_W:0] stop_count_i
);
    import vee_pkg::*;
    logic [16:0] ctrl_shadow;
    wire access_w = apb_i.psel && apb_i.penable && ce_i;
    wire [11:0] off_w = apb_i.paddr[11:0];
    wire mapped_w = apb_i.paddr[31:12] == 20'h00000 && (off_w inside
        {`VEE_OFF_CTRL, `VEE_OFF_CNT_LO, `VEE_OFF_CNT_HI, `VEE_OFF_STATUS});
    wire ctrl_wr_w = access_w && apb_i.pwrite && mapped_w && off_w == 12'h000;
    // clear is write-one and never reads back, so it stays out of the shadow
    wire [16:0] next_ctrl = {
        apb_i.pstrb[2] ? apb_i.pwdata[16] : ctrl_shadow[16],
        apb_i.pstrb[1] ? apb_i.pwdata[15:8] : ctrl_shadow[15:8],
        apb_i.pstrb[0] ? apb_i.pwdata[7:0] : ctrl_shadow[7:0]};
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ctrl_shadow <= 17'h00000;
        end else if (ctrl_wr_w) begin
            ctrl_shadow <= next_ctrl;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence rd_of(logic [11:0] off);
        apb_i.psel && !apb_i.penable && !apb_i.pwrite &&
        apb_i.paddr == {20'h00000, off} ##1 apb_o.pready;
    endsequence
    sequence rd_refused;
        apb_i.psel && !apb_i.penable && !apb_i.pwrite
        ##1 apb_o.pready && apb_o.pslverr;
    endsequence
    rdy_follows_a: assert property (apb_o.pready == access_w)
        else $error("pready does not follow the access phase");
    err_needs_rdy_a: assert property (apb_o.pslverr |-> apb_o.pready)
        else $error("pslverr without pready");
    addr_decode_a: assert property (access_w |-> apb_o.pslverr == !mapped_w)
        else $error("pslverr does not match the address map");
    unmapped_zero_a: assert property (rd_refused |-> apb_o.prdata == 32'h0)
        else $error("refused read returned data");
    rdata_hold_a: assert property (
        !(apb_i.psel && !apb_i.penable && !apb_i.pwrite) |=>
        $stable(apb_o.prdata))
        else $error("read data moved without a read setup");
    side_flag_a: assert property (rd_of(`VEE_OFF_STATUS) |->
        apb_o.prdata[0] == ({$past(stop_id_i), 1'b0} < $past(stop_count_i)))
        else $error("side flag wrong for this stop");
    ctrl_back_a: assert property (rd_of(`VEE_OFF_CTRL) |->
        apb_o.prdata == {15'h0000, ctrl_shadow})
        else $error("control readback differs from last write");
    cnt_hi_top_a: assert property (rd_of(`VEE_OFF_CNT_HI) |->
        apb_o.prdata[31:16] == 16'h0000)
        else $error("count high word has bits above the counter");
endmodule : vee_counter_monitor

bind vee_counter vee_counter_monitor #(.CNT_W(CNT_W), .STOP_W(STOP_W),
    .STARVE_LIMIT(STARVE_LIMIT)) u_mon (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .ce_i(ce_i), .apb_i(apb_i), .apb_o(apb_o),
    .egress_i(egress_i), .ring_i(ring_i), .stop_id_i(stop_id_i),
    .stop_count_i(stop_count_i));

/* File: dv/vee_counter_tb.sv */
`timescale 1ns/10ps
`include "vee_consts.svh"
module vee_counter_tb;
    import vee_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic ce_i = 1'b1;
    vee_apb_req_s apb_i = '0;
    vee_apb_rsp_s apb_o;
    vee_egress_s [`VEE_NSUB-1:0] egress_i;
    vee_ring_s ring_i = '0;
    logic [5:0] stop_id_i = 6'h03;
    logic [6:0] stop_count_i = 7'h08;
    int err_total = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [31:0] rd_data;
    logic rd_err;
    // short starvation window keeps the run brief
    vee_counter #(.STARVE_LIMIT(4)) uut (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .ce_i(ce_i), .apb_i(apb_i), .apb_o(apb_o),
        .egress_i(egress_i), .ring_i(ring_i), .stop_id_i(stop_id_i),
        .stop_count_i(stop_count_i));
    always #5 clk_i = ~clk_i;
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            end_of_test();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one edge of gap first, so back-to-back calls never drive twice
    task automatic xfer(input logic wr, input logic [11:0] off,
                        input logic [31:0] d, input logic [3:0] st);
        @(posedge clk_i);
        apb_i <= '{paddr: {20'h00000, off}, psel: 1'b1, penable: 1'b0,
                   pwrite: wr, pwdata: d, pstrb: st};
        @(posedge clk_i);
        apb_i.penable <= 1'b1;
        do @(posedge clk_i); while (apb_o.pready !== 1'b1);
        rd_data = apb_o.prdata;
        rd_err = apb_o.pslverr;
        apb_i.psel <= 1'b0;
        apb_i.penable <= 1'b0;
    endtask : xfer
    task automatic rd_chk(input string what, input logic [11:0] off,
                          input logic [31:0] exp, input logic eerr);
        xfer(1'b0, off, 32'h0, 4'h0);
        chk(what, exp, rd_data);
        chk("pslverr", {31'h0, eerr}, {31'h0, rd_err});
    endtask : rd_chk
    // clear, count for 11 edges less frz frozen ones, stop, read back
    task automatic run(input logic [7:0] ev, input logic [7:0] m,
                       input logic [5:0] sid, input logic [3:0] occ,
                       input logic [3:0] own, input int frz,
                       input logic [31:0] per);
        stop_id_i <= sid;
        ring_i <= '{occupied: occ, own_inject: own};
        xfer(1'b1, `VEE_OFF_CTRL, {14'h0, 2'b10, m, ev}, 4'hF);
        xfer(1'b1, `VEE_OFF_CTRL, {14'h0, 2'b01, m, ev}, 4'hF);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_i);
            ce_i <= (i >= frz);
        end
        xfer(1'b1, `VEE_OFF_CTRL, {16'h0, m, ev}, 4'hF);
        rd_chk("count", `VEE_OFF_CNT_LO, per * (11 - frz), 1'b0);
    endtask : run
    initial begin
        // every subclass holds k+1 entries and gets no send until the starve end check
        for (int k = 0; k < `VEE_NSUB; k++) begin
            egress_i[k] = '{fill: 6'(k + 1), alloc: 1'b1, refused: 1'b1,
                            sent: 1'b0};
        end
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd_chk("ctrl", `VEE_OFF_CTRL, 32'h0, 1'b0);
        rd_chk("cnt_lo", `VEE_OFF_CNT_LO, 32'h0, 1'b0);
        rd_chk("unmapped", 12'h010, 32'h0, 1'b1);
        xfer(1'b1, 12'h020, 32'hFFFFFFFF, 4'hF);
        chk("wr pslverr", 32'h1, {31'h0, rd_err});
        run(8'h90, 8'h7F, 6'h03, 4'h0, 4'h0, 0, 32'd28);
        xfer(1'b1, `VEE_OFF_CNT_LO, 32'hFFFFFFFF, 4'hF);
        rd_chk("cnt kept", `VEE_OFF_CNT_LO, 32'd308, 1'b0);
        rd_chk("cnt_hi", `VEE_OFF_CNT_HI, 32'h0, 1'b0);
        run(8'h90, 8'h50, 6'h03, 4'h0, 4'h0, 0, 32'd12);
        run(8'h90, 8'h00, 6'h03, 4'h0, 4'h0, 0, 32'd0);
        run(8'h91, 8'h03, 6'h03, 4'h0, 4'h0, 0, 32'd17);
        run(8'h92, 8'h7F, 6'h03, 4'h0, 4'h0, 0, 32'd7);
        run(8'h93, 8'h02, 6'h03, 4'h0, 4'h0, 0, 32'd1);
        run(8'h96, 8'h0F, 6'h03, 4'h0, 4'h0, 3, 32'd4);
        run(8'h97, 8'h03, 6'h03, 4'h0, 4'h0, 0, 32'd2);
        run(8'h97, 8'h01, 6'h03, 4'h0, 4'h0, 0, 32'd1);
        run(8'h98, 8'h11, 6'h03, 4'h0, 4'h0, 0, 32'd2);
        run(8'h99, 8'h01, 6'h03, 4'h0, 4'h0, 0, 32'd1);
        run(8'h9A, 8'h7F, 6'h03, 4'h0, 4'h0, 0, 32'd7);
        run(8'h9B, 8'h07, 6'h03, 4'h0, 4'h0, 0, 32'd3);
        run(8'hB0, 8'h05, 6'h03, 4'h7, 4'h0, 0, 32'd2);
        run(8'hB0, 8'h08, 6'h03, 4'h7, 4'h0, 0, 32'd0);
        run(8'hB0, 8'h08, 6'h04, 4'h7, 4'h0, 0, 32'd1);
        run(8'hB0, 8'h02, 6'h04, 4'h7, 4'h0, 0, 32'd0);
        run(8'hB0, 8'h01, 6'h03, 4'h7, 4'h1, 0, 32'd0);
        run(8'hB0, 8'h0F, 6'h03, 4'hF, 4'h1, 0, 32'd3);
        run(8'h55, 8'hFF, 6'h03, 4'hF, 4'h0, 0, 32'd0);
        rd_chk("status", `VEE_OFF_STATUS, 32'h00000FFF, 1'b0);
        // a send ends the wait of subclass 0 before the status is latched
        egress_i[0].sent <= 1'b1;
        rd_chk("starve end", `VEE_OFF_STATUS, 32'h00000FFD, 1'b0);
        egress_i[0].sent <= 1'b0;
        xfer(1'b1, `VEE_OFF_CTRL, 32'h00000C91, 4'hF);
        xfer(1'b1, `VEE_OFF_CTRL, 32'h00013390, 4'h2);
        rd_chk("ctrl strobe", `VEE_OFF_CTRL, 32'h00003391, 1'b0);
        // reset in mid-run must clear a running counter and its control
        xfer(1'b1, `VEE_OFF_CTRL, 32'h0001FF90, 4'hF);
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd_chk("ctrl reset", `VEE_OFF_CTRL, 32'h0, 1'b0);
        rd_chk("cnt reset", `VEE_OFF_CNT_LO, 32'h0, 1'b0);
        end_of_test();
    end
endmodule : vee_counter_tb
